// ---- design/dsc_map.svh ----
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
// control word bit positions
`define DSC_CW_ON1 0
`define DSC_CW_ON2 1
`define DSC_CW_ON3 2
`define DSC_CW_COAST 3
`define DSC_CW_QSTOP 4
`define DSC_CW_VALID 10
// status word bit positions
`define DSC_SW_CTRL_RDY 0
`define DSC_SW_DRV_RDY 1
`define DSC_SW_NO_COAST 2
`define DSC_SW_TRIP 3
`define DSC_SW_SECOND_OFF 4
`define DSC_SW_THIRD_OFF 5
`define DSC_SW_START_DIS 6
`define DSC_SW_WARN 7
`define DSC_SW_AT_REF 8
`define DSC_SW_SERIAL 9
`define DSC_SW_IN_RANGE 10
`define DSC_SW_RUNNING 11
// scaling
`define DSC_FULL_SCALE 16'h4000
`define DSC_FS_SHIFT 14
// setting reset values and limits
`define DSC_ADDR_RESET 8'h01
`define DSC_ADDR_MAX_NATIVE 8'hF7
`define DSC_ADDR_MAX_BAS 8'hFF
`define DSC_ADDR_MAX_MODBUS 8'hF7
`define DSC_ADDR_MIN_NATIVE 8'h00
`define DSC_ADDR_MIN_OTHER 8'h01
`define DSC_RATE_RESET 3'h5
`define DSC_RATE_MAX 3'h5
`define DSC_SRC_RESET 2'h3
`endif

// ---- design/dsc_pkg.sv ----
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_SRC_DIN = 2'h0,
    DSC_SRC_SER = 2'h1,
    DSC_SRC_AND = 2'h2,
    DSC_SRC_OR = 2'h3
  } dsc_src_t;
  typedef enum logic [1:0] {
    DSC_PROTO_NATIVE = 2'h0,
    DSC_PROTO_BAS = 2'h1,
    DSC_PROTO_RSVD = 2'h2,
    DSC_PROTO_MODBUS = 2'h3
  } dsc_proto_t;
  // start-disable latch states, gray along the path
  typedef enum logic [1:0] {
    DSC_ST_LOCKED = 2'b00,
    DSC_ST_ENABLED = 2'b01
  } dsc_lock_t;
  // panel settings write bundle
  typedef struct packed {
    logic wr_addr;
    logic wr_rate;
    logic wr_coast;
    logic wr_qstop;
    logic [7:0] data;
  } dsc_panel_wr_t;
  // drive state inputs
  typedef struct packed {
    logic ready;
    logic tripped;
    logic trip_reset;
    logic warning;
    logic at_ref;
    logic serial_ok;
    logic in_range;
    logic running;
  } dsc_drive_t;
endpackage

// ---- design/dsc_cmd.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dsc_map.svh"
// Notes on behaviour
// - control ready needs ON1-3 and drive ready
// - no-coast bit needs bits 0-3, no trip
// - status bit 4 inverts control bit 1
// - status bit 5 inverts control bit 2
// - start disable set by trip reset/off/power
// - start disable cleared by 0 on bit0, 1s
// - status bit 3 shows trip
// - reference is signed 16-bit, 16384 is full
// - reference 0..16384 maps min to max ref
// - negative reference reverses direction
// - output frequency scaled same to limits
// - node address range by protocol, default 1
// - address and rate writable only from panel
// - rate codes 0..5, default 5
// - source select codes 0..3, default 3
// - coast truth table per source select
// - coast input and bit 3 active low
// - quick stop same table, active low
module dsc_cmd
  import dsc_pkg::*;
#(
  parameter int REF_W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // serial telegram from the bus master
  input wire logic TEL_VALID,
  input wire logic [15:0] TEL_CTRL,
  input wire logic [REF_W-1:0] TEL_REF,
  input wire logic TEL_WR_SETTING,
  // drive state and limits
  input wire dsc_drive_t DRIVE,
  input wire dsc_proto_t PROTO,
  input wire logic [REF_W-1:0] REF_MIN,
  input wire logic [REF_W-1:0] REF_MAX,
  input wire logic [REF_W-1:0] FREQ_LOW,
  input wire logic [REF_W-1:0] FREQ_HIGH,
  input wire logic [REF_W-1:0] FREQ_NOW,
  // digital inputs, active low
  input wire logic COAST_IN_N,
  input wire logic QSTOP_IN_N,
  // local operator panel
  input wire dsc_panel_wr_t PANEL,
  // answers to the master
  output logic [15:0] STATUS_WORD,
  output logic [15:0] FREQ_WORD,
  output logic SETTING_REJECT,
  // drive commands
  output logic [REF_W-1:0] SPEED_REF,
  output logic REVERSE,
  output logic COAST,
  output logic QUICK_STOP,
  // settings readback
  output logic [7:0] NODE_ADDR,
  output logic [2:0] BIT_RATE,
  output logic [1:0] COAST_SRC,
  output logic [1:0] QSTOP_SRC
);

  // command merge: returns 1 when the function is requested (active low)
  function automatic logic merge_stop(input logic [1:0] sel,
                                      input logic din_n,
                                      input logic ser_n);
    logic req;
    req = 1'b0;
    case (dsc_src_t'(sel))
      DSC_SRC_DIN: req = ~din_n;
      DSC_SRC_SER: req = ~ser_n;
      DSC_SRC_AND: req = ~din_n & ~ser_n;
      DSC_SRC_OR: req = ~(din_n & ser_n);
      default: req = 1'b1;
    endcase
    return req;
  endfunction

  // linear map of 0..full scale onto lo..hi
  function automatic logic [REF_W-1:0] span_map(input logic [REF_W-1:0] v,
                                                input logic [REF_W-1:0] lo,
                                                input logic [REF_W-1:0] hi);
    logic [2*REF_W+1:0] prod;
    logic [REF_W:0] diff;
    diff = {1'b0, hi} - {1'b0, lo};
    prod = {{(REF_W+1){1'b0}}, diff} * {{(REF_W+1){1'b0}}, v};
    return REF_W'(lo + REF_W'(prod >> `DSC_FS_SHIFT));
  endfunction

  // inverse map of lo..hi onto 0..full scale
  function automatic logic [REF_W-1:0] span_unmap(input logic [REF_W-1:0] f,
                                                  input logic [REF_W-1:0] lo,
                                                  input logic [REF_W-1:0] hi);
    logic [REF_W-1:0] diff;
    logic [REF_W-1:0] off;
    logic [2*REF_W-1:0] num;
    diff = hi - lo;
    off = (f > lo) ? REF_W'(f - lo) : '0;
    num = {off, {REF_W{1'b0}}} >> (REF_W - `DSC_FS_SHIFT);
    if (diff == '0) begin
      return '0;
    end
    return REF_W'(num / {{REF_W{1'b0}}, diff});
  endfunction

  logic [15:0] ctrl_q, ctrl_d;
  logic [REF_W-1:0] ref_q, ref_d;
  logic [7:0] addr_q, addr_d;
  logic [2:0] rate_q, rate_d;
  logic [1:0] coast_sel_q, coast_sel_d;
  logic [1:0] qstop_sel_q, qstop_sel_d;
  dsc_lock_t lock_q, lock_d;
  logic [15:0] status_q, status_d;
  logic [15:0] freq_q, freq_d;
  logic [REF_W-1:0] speed_q, speed_d;
  logic rev_q, rev_d;
  logic coast_q, coast_d;
  logic qstop_q, qstop_d;
  logic reject_q, reject_d;
  logic prev_off_q;

  // control word fields
  wire logic on1 = ctrl_q[`DSC_CW_ON1];
  wire logic on2 = ctrl_q[`DSC_CW_ON2];
  wire logic on3 = ctrl_q[`DSC_CW_ON3];
  wire logic cw_coast_n = ctrl_q[`DSC_CW_COAST];
  wire logic cw_qstop_n = ctrl_q[`DSC_CW_QSTOP];
  wire logic cw_valid = ctrl_q[`DSC_CW_VALID];

  // latch each received telegram; reference is raw two's complement
  assign ctrl_d = TEL_VALID ? TEL_CTRL : ctrl_q;
  assign ref_d = TEL_VALID ? TEL_REF : ref_q;

  // serial setting writes are refused, only the panel changes them
  assign reject_d = TEL_VALID & TEL_WR_SETTING;

  // address accepted only inside the protocol's range
  wire logic [7:0] addr_min = (PROTO == DSC_PROTO_NATIVE) ?
    `DSC_ADDR_MIN_NATIVE : `DSC_ADDR_MIN_OTHER;
  wire logic [7:0] addr_max = (PROTO == DSC_PROTO_BAS) ? `DSC_ADDR_MAX_BAS :
    (PROTO == DSC_PROTO_MODBUS) ? `DSC_ADDR_MAX_MODBUS :
    `DSC_ADDR_MAX_NATIVE;
  wire logic addr_ok = (PANEL.data >= addr_min) &&
    (PANEL.data <= addr_max);
  assign addr_d = (PANEL.wr_addr && addr_ok) ? PANEL.data : addr_q;

  // out-of-range rate codes are ignored, keeping the old rate
  wire logic rate_ok = PANEL.data[2:0] <= `DSC_RATE_MAX &&
    PANEL.data[7:3] == 5'h00;
  assign rate_d = (PANEL.wr_rate && rate_ok) ? PANEL.data[2:0] : rate_q;

  // all four source codes are legal
  assign coast_sel_d = PANEL.wr_coast ? PANEL.data[1:0] : coast_sel_q;
  assign qstop_sel_d = PANEL.wr_qstop ? PANEL.data[1:0] : qstop_sel_q;

  // start disable: an off edge from ON2 or ON3 or trip reset locks, set wins over clear
  wire logic off_now = ~on2 | ~on3;
  wire logic lock_set = DRIVE.trip_reset | (off_now & ~prev_off_q);
  wire logic lock_clr = ~on1 & on2 & on3 & cw_valid;
  assign lock_d = lock_set ? DSC_ST_LOCKED :
    lock_clr ? DSC_ST_ENABLED : lock_q;

  // status word assembly
  always_comb begin
    status_d = 16'h0000;
    status_d[`DSC_SW_CTRL_RDY] = on1 & on2 & on3 & DRIVE.ready;
    status_d[`DSC_SW_DRV_RDY] = DRIVE.ready & coast_q;
    status_d[`DSC_SW_NO_COAST] = on1 & on2 & on3 & cw_coast_n &
      ~DRIVE.tripped;
    status_d[`DSC_SW_TRIP] = DRIVE.tripped;
    status_d[`DSC_SW_SECOND_OFF] = ~on2;
    status_d[`DSC_SW_THIRD_OFF] = ~on3;
    status_d[`DSC_SW_START_DIS] = (lock_q == DSC_ST_LOCKED);
    status_d[`DSC_SW_WARN] = DRIVE.warning;
    status_d[`DSC_SW_AT_REF] = DRIVE.at_ref;
    status_d[`DSC_SW_SERIAL] = DRIVE.serial_ok;
    status_d[`DSC_SW_IN_RANGE] = DRIVE.in_range;
    status_d[`DSC_SW_RUNNING] = DRIVE.running;
  end

  // reference magnitude clamped to full scale before the span map
  wire logic ref_neg = ref_q[REF_W-1];
  wire logic [REF_W-1:0] ref_mag = ref_neg ? REF_W'(-ref_q) : ref_q;
  wire logic [REF_W-1:0] ref_clip = (ref_mag > `DSC_FULL_SCALE) ?
    `DSC_FULL_SCALE : ref_mag;
  assign speed_d = span_map(ref_clip, REF_MIN, REF_MAX);
  assign rev_d = ref_neg;

  // present frequency back onto the same scale
  assign freq_d = 16'(span_unmap(FREQ_NOW, FREQ_LOW, FREQ_HIGH));

  // both stop inputs are active low on pin and bit
  assign coast_d = merge_stop(coast_sel_q, COAST_IN_N, cw_coast_n);
  assign qstop_d = merge_stop(qstop_sel_q, QSTOP_IN_N, cw_qstop_n);

  // control word resets to all ones so power-up is not an off edge
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= 16'hFFFF;
      ref_q <= '0;
      prev_off_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ref_q <= ref_d;
      prev_off_q <= off_now;
    end
  end

  // settings; power-up locks start as a start-disable event
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_q <= `DSC_ADDR_RESET;
      rate_q <= `DSC_RATE_RESET;
      coast_sel_q <= `DSC_SRC_RESET;
      qstop_sel_q <= `DSC_SRC_RESET;
      lock_q <= DSC_ST_LOCKED;
    end else begin
      addr_q <= addr_d;
      rate_q <= rate_d;
      coast_sel_q <= coast_sel_d;
      qstop_sel_q <= qstop_sel_d;
      lock_q <= lock_d;
    end
  end

  // output registers; coast/qstop start asserted as the safe state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_q <= 16'h0000;
      freq_q <= 16'h0000;
      speed_q <= '0;
      rev_q <= 1'b0;
      coast_q <= 1'b1;
      qstop_q <= 1'b1;
      reject_q <= 1'b0;
    end else begin
      status_q <= status_d;
      freq_q <= freq_d;
      speed_q <= speed_d;
      rev_q <= rev_d;
      coast_q <= coast_d;
      qstop_q <= qstop_d;
      reject_q <= reject_d;
    end
  end

  assign STATUS_WORD = status_q;
  assign FREQ_WORD = freq_q;
  assign SETTING_REJECT = reject_q;
  assign SPEED_REF = speed_q;
  assign REVERSE = rev_q;
  assign COAST = coast_q;
  assign QUICK_STOP = qstop_q;
  assign NODE_ADDR = addr_q;
  assign BIT_RATE = rate_q;
  assign COAST_SRC = coast_sel_q;
  assign QSTOP_SRC = qstop_sel_q;

endmodule
`default_nettype wire

// ---- tb/dsc_cmd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_cmd_checker
  import dsc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // requests
  input wire logic TEL_VALID,
  input wire logic [15:0] TEL_CTRL,
  input wire logic TEL_WR_SETTING,
  input wire dsc_drive_t DRIVE,
  input wire dsc_proto_t PROTO,
  input wire dsc_panel_wr_t PANEL,
  // answers
  input wire logic [15:0] STATUS_WORD,
  input wire logic SETTING_REJECT,
  input wire logic COAST,
  input wire logic QUICK_STOP,
  input wire logic [7:0] NODE_ADDR,
  input wire logic [2:0] BIT_RATE,
  // source selections
  input wire logic [1:0] COAST_SRC,
  input wire logic [1:0] QSTOP_SRC
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // status flags follow the telegram two edges later
  AST_SECOND_OFF_FLAG: assert property (
    TEL_VALID ##2 1 |-> STATUS_WORD[4] == !$past(TEL_CTRL[1], 2))
    else $error("second off flag wrong");
  AST_THIRD_OFF_FLAG: assert property (
    TEL_VALID |-> ##2 STATUS_WORD[5] == !$past(TEL_CTRL[2], 2))
    else $error("third off flag wrong");
  AST_TRIP_FLAG: assert property (
    1'b1 |=> STATUS_WORD[3] == $past(DRIVE.tripped))
    else $error("trip flag wrong");
  AST_TRIP_RESET: assert property (
    DRIVE.trip_reset |-> ##2 STATUS_WORD[6])
    else $error("start disable not set");
  AST_SER_REJECT: assert property (
    TEL_VALID && TEL_WR_SETTING |=> SETTING_REJECT)
    else $error("serial setting write not refused");
  AST_SETTING_HOLD: assert property (
    !(PANEL.wr_addr || PANEL.wr_rate) |=> $stable({NODE_ADDR, BIT_RATE}))
    else $error("setting changed without panel");
  AST_RATE_CODE: assert property (BIT_RATE <= 3'h5)
    else $error("rate code out of range");
  AST_ADDR_BAS: assert property (
    PANEL.wr_addr && PROTO == DSC_PROTO_BAS && PANEL.data != 8'h00
    |=> NODE_ADDR == $past(PANEL.data))
    else $error("address write lost");
  // serial or or-mode sources obey a serial 0
  AST_SER_COAST: assert property (
    TEL_VALID && !TEL_CTRL[3] && COAST_SRC[0] |-> ##2 COAST)
    else $error("coast missing");
  AST_SER_QSTOP: assert property (
    TEL_VALID && !TEL_CTRL[4] && QSTOP_SRC[0] |-> ##2 QUICK_STOP)
    else $error("quick stop missing");
endmodule
bind dsc_cmd dsc_cmd_checker u_chk (.CLK, .RESET_N, .TEL_VALID, .TEL_CTRL,
  .TEL_WR_SETTING, .DRIVE, .PROTO, .PANEL, .STATUS_WORD, .SETTING_REJECT,
  .COAST, .QUICK_STOP, .NODE_ADDR, .BIT_RATE, .COAST_SRC, .QSTOP_SRC);
`default_nettype wire

// ---- tb/dsc_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_master_model #(
  parameter logic [2:0] RATE = 3'h5
) (
  // clock and drive rate
  input wire logic clk,
  input wire logic [2:0] rate,
  // telegram
  output logic tel_valid,
  output logic [15:0] tel_ctrl,
  output logic [15:0] tel_ref,
  output logic tel_wr
);
  // idle lines before the first telegram
  initial begin
    tel_valid = 1'b0;
    tel_wr = 1'b0;
    tel_ctrl = 16'hFFFF;
    tel_ref = 16'h0000;
  end
  // one telegram; a master at another rate is never heard
  task automatic send(input logic [15:0] c, input logic neg,
                      input logic [15:0] mag, input logic wr);
    @(posedge clk);
    if (rate === RATE) begin
      tel_ctrl <= c;
      tel_ref <= neg ? ~mag + 16'h0001 : mag;
      tel_wr <= wr;
      tel_valid <= 1'b1;
      @(posedge clk);
      tel_valid <= 1'b0;
      tel_wr <= 1'b0;
      tel_ctrl <= ~c; // released lines show junk
      tel_ref <= ~tel_ref;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/dsc_cmd_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsc_cmd_tb
  import dsc_pkg::*;
;
  logic clk, rst_n, tel_valid, tel_wr, cin_n, qin_n;
  logic reject, reverse, coast, qstop;
  logic [15:0] tel_ctrl, tel_ref, ref_max, f_high, f_now;
  logic [15:0] status, freq_w, speed;
  logic [7:0] addr;
  logic [2:0] rate;
  logic [1:0] csrc, qsrc;
  dsc_drive_t drive;
  dsc_proto_t proto;
  dsc_panel_wr_t panel;
  int error_cnt, cmp_count;
  // block under test; reference and frequency floors held at zero
  dsc_cmd u_dut (.CLK(clk), .RESET_N(rst_n), .TEL_VALID(tel_valid),
    .TEL_CTRL(tel_ctrl), .TEL_REF(tel_ref), .TEL_WR_SETTING(tel_wr),
    .DRIVE(drive), .PROTO(proto), .REF_MIN(16'h0000), .REF_MAX(ref_max),
    .FREQ_LOW(16'h0000), .FREQ_HIGH(f_high), .FREQ_NOW(f_now),
    .COAST_IN_N(cin_n), .QSTOP_IN_N(qin_n), .PANEL(panel),
    .STATUS_WORD(status), .FREQ_WORD(freq_w), .SETTING_REJECT(reject),
    .SPEED_REF(speed), .REVERSE(reverse), .COAST(coast),
    .QUICK_STOP(qstop), .NODE_ADDR(addr), .BIT_RATE(rate),
    .COAST_SRC(csrc), .QSTOP_SRC(qsrc));
  dsc_master_model u_mst (.clk(clk), .rate(rate), .tel_valid(tel_valid),
    .tel_ctrl(tel_ctrl), .tel_ref(tel_ref), .tel_wr(tel_wr));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // three edges cover the two-stage answer path
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pc(input dsc_proto_t p, input logic [3:0] s,
                    input logic [7:0] d, input logic [7:0] ea,
                    input logic [2:0] er);
    @(posedge clk);
    proto <= p;
    panel <= {s, d};
    @(posedge clk);
    panel <= '0;
    #1;
    chk(16'({addr, rate}), 16'({ea, er}));
  endtask
  task automatic t_power;
    @(posedge clk);
    #1;
    chk(16'({addr, rate}), 16'h000D);
    chk(16'({csrc, qsrc, status[6]}), 16'h001F);
  endtask
  task automatic t_enable;
    logic [15:0] cw [5] = '{16'h047E, 16'h047F, 16'h047D, 16'h047E, 16'h047B};
    logic [4:0] ex [5] = '{5'h00, 5'h03, 5'h14, 5'h00, 5'h18};
    for (int i = 0; i < 5; i++) begin
      u_mst.send(cw[i], 1'b0, 16'h0000, 1'b0);
      settle;
      chk(16'({status[6:4], status[2], status[0]}), 16'(ex[i]));
    end
  endtask
  task automatic t_trip;
    u_mst.send(16'h047E, 1'b0, 16'h0000, 1'b0);
    u_mst.send(16'h047F, 1'b0, 16'h0000, 1'b0);
    drive.tripped <= 1'b1;
    settle;
    chk(16'(status[6:2]), 16'h0002);
    @(posedge clk);
    drive.tripped <= 1'b0;
    drive.trip_reset <= 1'b1;
    @(posedge clk);
    drive.trip_reset <= 1'b0;
    settle;
    chk(16'(status[6:2]), 16'h0011);
    // drive state bits pass straight through; no coast so bit 1 low
    @(posedge clk);
    drive <= '{ready: 1'b1, warning: 1'b1, at_ref: 1'b1, serial_ok: 1'b1,
      in_range: 1'b1, running: 1'b1, default: 1'b0};
    settle;
    chk(16'({status[15:7], status[1]}), 16'h003E);
    @(posedge clk);
    drive <= '{ready: 1'b1, default: 1'b0};
    settle;
  endtask
  // odd steps carry a negative reference
  task automatic t_ref;
    logic [15:0] mg [4] = '{16'h2000, 16'h2000, 16'h4000, 16'h0004};
    for (int i = 0; i < 4; i++) begin
      u_mst.send(16'h047F, i[0], mg[i], 1'b0);
      settle;
      chk(speed, 16'((32'(ref_max) * mg[i]) >> 14));
      chk(16'(reverse), 16'(i[0]));
    end
  endtask
  task automatic t_freq;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      f_now <= 16'(25 * i);
      settle;
      chk(freq_w, 16'((25 * i * 16384) / 50));
    end
  endtask
  task automatic t_settings;
    u_mst.send(16'h047F, 1'b0, 16'h0000, 1'b1);
    #1;
    chk(16'({reject, addr}), 16'h0101);
    pc(DSC_PROTO_NATIVE, 4'h8, 8'hF8, 8'h01, 3'h5);
    pc(DSC_PROTO_NATIVE, 4'h8, 8'h00, 8'h00, 3'h5);
    pc(DSC_PROTO_MODBUS, 4'h8, 8'hF7, 8'hF7, 3'h5);
    pc(DSC_PROTO_MODBUS, 4'h8, 8'h00, 8'hF7, 3'h5);
    pc(DSC_PROTO_BAS, 4'h8, 8'hFF, 8'hFF, 3'h5);
    pc(DSC_PROTO_BAS, 4'h8, 8'h00, 8'hFF, 3'h5);
    pc(DSC_PROTO_NATIVE, 4'h4, 8'h06, 8'hFF, 3'h5);
    pc(DSC_PROTO_NATIVE, 4'h4, 8'h00, 8'hFF, 3'h0);
    pc(DSC_PROTO_NATIVE, 4'h4, 8'h05, 8'hFF, 3'h5);
  endtask
  // every source code against every input pair
  task automatic t_merge;
    logic [1:0] s;
    logic e;
    for (int i = 0; i < 16; i++) begin
      s = 2'(i >> 2);
      e = s == 0 ? !i[1] : s == 1 ? !i[0] : s == 2 ? !(i[1] | i[0])
        : !(i[1] & i[0]);
      pc(DSC_PROTO_NATIVE, 4'h3, 8'(s), 8'hFF, 3'h5);
      cin_n <= i[1];
      qin_n <= i[1];
      u_mst.send(i[0] ? 16'h041F : 16'h0407, 1'b0, 16'h0000, 1'b0);
      settle;
      chk(16'({coast, csrc}), 16'({e, s}));
      chk(16'({qstop, qsrc}), 16'({e, s}));
    end
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    drive = '{ready: 1'b1, default: 1'b0};
    proto = DSC_PROTO_NATIVE;
    ref_max = 16'h1000;
    f_high = 16'h0032;
    f_now = 16'h0000;
    cin_n = 1'b1;
    qin_n = 1'b1;
    panel = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_power;
    t_enable;
    t_trip;
    t_ref;
    t_freq;
    t_settings;
    t_merge;
    complete_run;
  end
endmodule
`default_nettype wire
